// File: verilog/rbm_regs.svh
// Register offsets, field positions and reset values of the receive ring manager.
`ifndef RBM_REGS_SVH
`define RBM_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RBM_OFS_CTRL     8'h00
`define RBM_OFS_FIRST    8'h04
`define RBM_OFS_END      8'h08
`define RBM_OFS_WPTR     8'h0c
`define RBM_OFS_RPTR     8'h10
`define RBM_OFS_STATUS   8'h14
`define RBM_OFS_MISSED   8'h18
`define RBM_OFS_DMAADDR  8'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RBM_CTRL_HALT    0
`define RBM_CTRL_ACCERR  1
`define RBM_CTRL_ACCRUNT 2
`define RBM_ST_OVF       0
`define RBM_ST_STOPPED   1
`define RBM_ST_BUSY      2

// ----------------------------------------------------------------------------
// Reset values and fixed figures
// ----------------------------------------------------------------------------
`define RBM_RST_PAGE     8'h01
`define RBM_RST_ENDPAGE  8'h02
`define RBM_HDR_LEN      8'h04
`define RBM_PAGE_LAST    8'hff
`define RBM_PAGE_BASE    8'h00
`define RBM_HDR_LASTIDX  2'h3

`endif

// File: verilog/rbm_pkg.sv
// Types shared by the receive ring manager and its surroundings.
package rbm_pkg;

	// ------------------------------------------------------------------------
	// Bus and stream carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} rbm_apb_req_t;

	typedef struct packed {
		logic       start;
		logic       valid;
		logic [7:0] data;
		logic       done;
		logic       crcErr;
		logic       alignErr;
		logic       runt;
	} rbm_rx_t;

	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  data;
	} rbm_mem_t;

	// ------------------------------------------------------------------------
	// State machine and full module state
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		RBM_IDLE = 3'b001,
		RBM_RECV = 3'b010,
		RBM_HDR  = 3'b100
	} rbm_state_t;

	typedef struct packed {
		rbm_state_t  state;
		logic [15:0] dmaAddr;
		logic [15:0] byteCnt;
		logic [1:0]  hdrIdx;
		logic [7:0]  nextPage;
		logic [7:0]  rxStatus;
		logic [7:0]  ringFirst;
		logic [7:0]  ringEnd;
		logic [7:0]  writePtr;
		logic [7:0]  readPtr;
		logic        halt;
		logic        acceptErr;
		logic        acceptRunt;
		logic        ovf;
		logic [7:0]  missed;
		logic [31:0] prdata;
		logic        pslverr;
		rbm_mem_t    mem;
	} rbm_regs_t;

endpackage

// File: verilog/rbm_ring_manager.sv
// Receive buffer ring manager: page linking, wrap, overflow abort and APB registers.
//
// Behaviour
// - Frames are stored in 256-byte pages inside the 64k byte buffer space.
// - Pages from first to end page form a ring; reaching end wraps to first.
// - Write pointer marks frame's first page; used for status and error restore.
// - Read pointer marks first unread frame; reaching it aborts reception.
// - Frame starts at write pointer page, leaving four bytes for its header.
// - A full page links forward to the next contiguous page, never skipping.
// - Before linking, check end page and wrap, then check read pointer and abort.
// - Ring overflow sets the sticky overflow flag in the event status.
// - After halt, a frame already in progress is finished before idling.
// - Without remote channel, frames may be removed before restarting.
// - While stopped, the missed-frame tally does not count.
// - Runt, CRC or alignment errors rewind to write pointer unless accepted.
// - Accepted frame gets header at write pointer, then pointer advances.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps

module rbm_ring_manager
	import rbm_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// APB register port
	input  wire rbm_pkg::rbm_apb_req_t apbReq,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Received byte stream from the receive path
	input  wire rbm_pkg::rbm_rx_t  rx,
	// Buffer memory write port
	output rbm_pkg::rbm_mem_t      mem,
	// Status levels
	output logic                   stopped,
	output logic                   ringOverflow
);
	import rbm_pkg::*;
	`include "rbm_regs.svh"

	rbm_regs_t s;
	rbm_regs_t next_s;

	// ------------------------------------------------------------------------
	// Ring helpers
	// ------------------------------------------------------------------------

	// Page after p, wrapped back to the first page when the end page is met.
	function automatic logic [7:0] ringNext(input logic [7:0] p, input logic [7:0] first,
		input logic [7:0] last);
		logic [7:0] n;
		n = p + 8'h01;
		if (n == last) begin
			n = first;
		end
		return n;
	endfunction

	logic       apbWr;
	logic       apbRd;
	logic       badFrame;
	logic [7:0] linkPage;
	logic [7:0] st;

	// Bus strobes; the write lands in the access phase, read data is sampled in setup.
	assign apbWr = apbReq.psel & apbReq.penable & apbReq.pwrite;
	assign apbRd = apbReq.psel & ~apbReq.penable;
	assign linkPage = ringNext(s.dmaAddr[15:8], s.ringFirst, s.ringEnd);
	assign badFrame = ((rx.crcErr | rx.alignErr) & ~s.acceptErr) | (rx.runt & ~s.acceptRunt);
	assign st = {5'h00, s.state != RBM_IDLE, stopped, s.ovf};

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------

	// Registers and the frame machine share one next-state copy of the whole state.
	always_comb begin
		next_s = s;
		next_s.mem.we = 1'b0;
		// Register writes from the host; they are taken in every state, halted too,
		// so the read pointer can be moved on before the device is restarted.
		if (apbWr) begin
			unique case (apbReq.paddr)
				`RBM_OFS_CTRL: begin
					next_s.halt = apbReq.pwdata[`RBM_CTRL_HALT];
					next_s.acceptErr = apbReq.pwdata[`RBM_CTRL_ACCERR];
					next_s.acceptRunt = apbReq.pwdata[`RBM_CTRL_ACCRUNT];
				end
				`RBM_OFS_FIRST:  next_s.ringFirst = apbReq.pwdata[7:0];
				`RBM_OFS_END:    next_s.ringEnd = apbReq.pwdata[7:0];
				`RBM_OFS_WPTR:   next_s.writePtr = apbReq.pwdata[7:0];
				`RBM_OFS_RPTR:   next_s.readPtr = apbReq.pwdata[7:0];
				`RBM_OFS_STATUS: begin
					if (apbReq.pwdata[`RBM_ST_OVF]) begin
						next_s.ovf = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// Read data is captured in the setup cycle so prdata comes from a flop.
		if (apbRd) begin
			next_s.pslverr = 1'b0;
			unique case (apbReq.paddr)
				`RBM_OFS_CTRL:    next_s.prdata = {29'h0, s.acceptRunt, s.acceptErr, s.halt};
				`RBM_OFS_FIRST:   next_s.prdata = {24'h0, s.ringFirst};
				`RBM_OFS_END:     next_s.prdata = {24'h0, s.ringEnd};
				`RBM_OFS_WPTR:    next_s.prdata = {24'h0, s.writePtr};
				`RBM_OFS_RPTR:    next_s.prdata = {24'h0, s.readPtr};
				`RBM_OFS_STATUS:  next_s.prdata = {24'h0, st};
				`RBM_OFS_MISSED:  next_s.prdata = {24'h0, s.missed};
				`RBM_OFS_DMAADDR: next_s.prdata = {16'h0, s.dmaAddr};
				default: begin
					next_s.prdata = 32'h0;
					next_s.pslverr = 1'b1;
				end
			endcase
		end
		// Frame machine.
		unique case (s.state)
			RBM_IDLE: begin
				// A halted device takes no new frame and does not tally it either.
				if (rx.start && !s.halt) begin
					next_s.dmaAddr = {s.writePtr, `RBM_HDR_LEN};
					next_s.byteCnt = 16'h0;
					next_s.state = RBM_RECV;
				end
			end
			RBM_RECV: begin
				// Halt is not looked at here, so a frame in flight always completes.
				if (rx.valid) begin
					next_s.mem.we = 1'b1;
					next_s.mem.addr = s.dmaAddr;
					next_s.mem.data = rx.data;
					next_s.byteCnt = s.byteCnt + 16'h1;
					if (s.dmaAddr[7:0] == `RBM_PAGE_LAST) begin
						if (linkPage == s.readPtr) begin
							// Abort rewinds to the write pointer page so the partial frame is reclaimed.
							next_s.ovf = 1'b1;
							next_s.missed = s.missed + 8'h01;
							next_s.dmaAddr = {s.writePtr, `RBM_PAGE_BASE};
							next_s.state = RBM_IDLE;
						end else begin
							next_s.dmaAddr = {linkPage, `RBM_PAGE_BASE};
						end
					end else begin
						next_s.dmaAddr = s.dmaAddr + 16'h1;
					end
				end else if (rx.done) begin
					if (badFrame) begin
						next_s.dmaAddr = {s.writePtr, `RBM_PAGE_BASE};
						next_s.state = RBM_IDLE;
					end else begin
						// Leftover bytes of the last page are given up.
						next_s.nextPage = (s.dmaAddr[7:0] == `RBM_PAGE_BASE) ?
							s.dmaAddr[15:8] : linkPage;
						next_s.rxStatus = {5'h00, rx.runt, rx.alignErr, rx.crcErr};
						next_s.hdrIdx = 2'h0;
						next_s.state = RBM_HDR;
					end
				end
			end
			RBM_HDR: begin
				// Header bytes: status, next page, count low, count high.
				next_s.mem.we = 1'b1;
				next_s.mem.addr = {s.writePtr, 6'h00, s.hdrIdx};
				unique case (s.hdrIdx)
					2'h0: next_s.mem.data = s.rxStatus;
					2'h1: next_s.mem.data = s.nextPage;
					2'h2: next_s.mem.data = s.byteCnt[7:0];
					2'h3: next_s.mem.data = s.byteCnt[15:8];
				endcase
				next_s.hdrIdx = s.hdrIdx + 2'h1;
				if (s.hdrIdx == `RBM_HDR_LASTIDX) begin
					next_s.writePtr = s.nextPage;
					next_s.dmaAddr = {s.nextPage, `RBM_PAGE_BASE};
					next_s.state = RBM_IDLE;
				end
			end
			default: begin
				next_s.state = RBM_IDLE; // An illegal one-hot code falls back to idle.
			end
		endcase
		// Missed tally is frozen while stopped; only a running device aborts frames.
		if (stopped) begin
			next_s.missed = s.missed;
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------

	// Device leaves reset halted so the host can set up the ring first.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
			s.state <= RBM_IDLE;
			s.halt <= 1'b1;
			s.ringFirst <= `RBM_RST_PAGE;
			s.ringEnd <= `RBM_RST_ENDPAGE;
			s.writePtr <= `RBM_RST_PAGE;
			s.readPtr <= `RBM_RST_PAGE;
		end else begin
			s <= next_s;
		end
	end

	// Outputs. Stopped waits for the frame machine to go idle, so a halt never
	// cuts a frame short, at the price of an unknown delay before the host sees it.
	assign stopped = s.halt && (s.state == RBM_IDLE);
	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = s.pslverr & apbReq.psel & apbReq.penable;
	assign mem = s.mem;
	assign ringOverflow = s.ovf;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	// All checks run on the controller clock and sleep through reset.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	logic stClr;
	logic abortNow;
	assign stClr = apbWr && apbReq.paddr == `RBM_OFS_STATUS && apbReq.pwdata[`RBM_ST_OVF];
	// A byte in the last slot of a page whose forward link meets the read pointer.
	assign abortNow = s.state == RBM_RECV && rx.valid && s.dmaAddr[7:0] == `RBM_PAGE_LAST
		&& linkPage == s.readPtr;

	// Overflow flag, frame start and byte stores.
	a_ovf_sticky: assert property (s.ovf && !stClr |=> s.ovf)
		else $error("Overflow flag dropped without a clear.");
	a_start_addr: assert property (s.state == RBM_IDLE && rx.start && !s.halt
		|=> s.dmaAddr == {$past(s.writePtr), `RBM_HDR_LEN} && s.state == RBM_RECV)
		else $error("Frame did not start four bytes into the write page.");
	a_byte_store: assert property (s.state == RBM_RECV && rx.valid
		|=> mem.we && mem.addr == $past(s.dmaAddr) && mem.data == $past(rx.data))
		else $error("Received byte was not stored at the DMA address.");

	// Page linking, wrap and abort at the read pointer.
	a_wrap_end: assert property (s.state == RBM_RECV && rx.valid
		&& s.dmaAddr[7:0] == `RBM_PAGE_LAST
		&& s.dmaAddr[15:8] + 8'h01 == s.ringEnd && s.ringFirst != s.readPtr
		|=> s.dmaAddr == {$past(s.ringFirst), `RBM_PAGE_BASE})
		else $error("End page was not wrapped to the first page.");
	a_link_next: assert property (s.state == RBM_RECV && rx.valid
		&& s.dmaAddr[7:0] == `RBM_PAGE_LAST && linkPage != s.readPtr
		|=> s.dmaAddr[7:0] == `RBM_PAGE_BASE && s.state == RBM_RECV)
		else $error("Page link went wrong.");
	a_abort_read: assert property (abortNow |=> s.ovf && s.state == RBM_IDLE)
		else $error("Reaching the read pointer did not abort.");
	a_abort_tally: assert property (abortNow |=> s.missed == $past(s.missed) + 8'h01)
		else $error("Aborted frame was not tallied.");
	a_idle_quiet: assert property (s.state == RBM_IDLE |=> !mem.we)
		else $error("Buffer written while no frame was being stored.");

	// Frame end: rejection, header and pointer advance.
	a_reject_rewind: assert property (s.state == RBM_RECV && !rx.valid && rx.done
		&& badFrame |=> s.state == RBM_IDLE && s.dmaAddr[15:8] == $past(s.writePtr))
		else $error("Rejected frame did not rewind to the write page.");
	a_reject_keep: assert property (s.state == RBM_RECV && !rx.valid && rx.done
		&& badFrame && !apbWr |=> $stable(s.writePtr))
		else $error("Rejected frame moved the write pointer.");
	a_header_len: assert property (s.state == RBM_HDR && s.hdrIdx == 2'h0
		|=> mem.we [*4] ##1 !mem.we)
		else $error("Header is not four bytes long.");
	a_ptr_advance: assert property (s.state == RBM_HDR && s.hdrIdx == `RBM_HDR_LASTIDX
		|=> s.writePtr == $past(s.nextPage) && s.state == RBM_IDLE)
		else $error("Write pointer did not advance after the header.");

	// Halt behaviour and the missed tally.
	a_tally_frozen: assert property (stopped |=> $stable(s.missed))
		else $error("Missed tally moved while stopped.");
	a_halt_finish: assert property (s.halt && s.state == RBM_RECV && !rx.valid
		&& !rx.done |=> s.state == RBM_RECV)
		else $error("Halt cut a frame short.");
	a_halt_blocks: assert property (s.halt && s.state == RBM_IDLE && rx.start
		|=> s.state == RBM_IDLE)
		else $error("Halted device took a new frame.");

	// Reachability of the main scenarios.
	c_accept: cover property (s.state == RBM_HDR && s.hdrIdx == `RBM_HDR_LASTIDX);
	c_wrap: cover property (s.state == RBM_RECV && rx.valid && s.dmaAddr[7:0] == `RBM_PAGE_LAST
		&& s.dmaAddr[15:8] + 8'h01 == s.ringEnd);
	c_overflow: cover property ($rose(s.ovf));
	c_reject: cover property (s.state == RBM_RECV && rx.done && !rx.valid && badFrame);
	c_halt_frame: cover property (s.halt && s.state == RBM_RECV && !rx.valid);

endmodule

// File: tb/rbm_mem_model.sv
// Behavioural buffer memory that records every byte the ring manager stores.
`timescale 1ns/10ps

module rbm_mem_model
	import rbm_pkg::*;
(
	// Clock
	input  wire logic              mclk,
	// Write port from the ring manager
	input  wire rbm_pkg::rbm_mem_t mem
);
	import rbm_pkg::*;

	// Whole 64k byte space; the counter lets the bench spot stray or missing strobes.
	logic [7:0] store [0:65535];
	int         writes = 0;

	// Every strobe is stored and counted.
	always @(posedge mclk) begin
		if (mem.we === 1'b1) begin
			store[mem.addr] <= mem.data;
			writes <= writes + 1;
		end
	end
endmodule

// File: tb/receive_buffer_ring_manager_tb.sv
// Self-checking testbench for the receive buffer ring manager.
`timescale 1ns/10ps
`include "rbm_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end

module receive_buffer_ring_manager_tb;
	import rbm_pkg::*;

	// Stimulus, observation and the bench's own copy of the ring state.
	logic         mclk = 1'b0;
	logic         sys_rst = 1'b1;
	rbm_apb_req_t apbReq = '0;
	rbm_rx_t      rx = '0;
	rbm_mem_t     mem;
	logic [31:0]  prdata, rd;
	logic         pready, pslverr, stopped, ringOverflow, err;
	logic [7:0]   fst, lst, wp, rp, missed, dat [$];
	logic [2:0]   ctl;
	int           mismatches = 0, cmp_count = 0, cyc = 0, seed;

	// Clock at 40 MHz.
	always #12.5 mclk = ~mclk;

	rbm_ring_manager u_dut (.mclk(mclk), .sys_rst(sys_rst), .apbReq(apbReq), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx(rx), .mem(mem), .stopped(stopped),
		.ringOverflow(ringOverflow));
	rbm_mem_model u_mem (.mclk(mclk), .mem(mem));

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// A hang is cut short beyond the host's 64000-cycle stop wait and the frames.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			mismatches++;
			results();
		end
	end

	// One APB transfer; the half-cycle wait lets the design's edge updates land.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge mclk);
		apbReq.penable <= 1'b1;
		// Only the bench timeout ends a wait for the answer.
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apbReq <= '0;
		@(negedge mclk);
	endtask

	// Reads a register and compares it.
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask

	// Drives start, random bytes with an occasional idle gap, then done with its error flags.
	task automatic send(input int n, input logic [2:0] fl);
		dat = {};
		@(posedge mclk);
		rx.start <= 1'b1;
		@(posedge mclk);
		rx.start <= 1'b0;
		for (int k = 0; k < n; k++) begin
			// An occasional idle cycle between bytes, as a real receive path leaves.
			if ($urandom % 8 == 0) begin
				rx.valid <= 1'b0;
				@(posedge mclk);
			end
			dat.push_back(8'($urandom));
			rx.valid <= 1'b1;
			rx.data <= dat[k];
			@(posedge mclk);
		end
		rx.valid <= 1'b0;
		rx.done <= 1'b1;
		{rx.runt, rx.alignErr, rx.crcErr} <= fl;
		@(posedge mclk);
		rx.done <= 1'b0;
		{rx.runt, rx.alignErr, rx.crcErr} <= 3'h0;
		repeat (10) @(posedge mclk);
	endtask

	// Sends a frame, then walks the ring as the device should and checks the result.
	task automatic frame(input string n, input int len, input logic [2:0] fl);
		logic [15:0] a;
		logic [7:0]  nx;
		int          w0, cnt;
		bit          ab, acc, ign;
		w0 = u_mem.writes;
		ign = ctl[0];
		acc = !((fl[0] | fl[1]) & !ctl[1]) && !(fl[2] & !ctl[2]);
		ab = 0;
		cnt = 0;
		a = {wp, `RBM_HDR_LEN};
		send(len, fl);
		for (int k = 0; k < len && !ab && !ign; k++) begin
			`CHK("data", dat[k], u_mem.store[a])
			cnt++;
			a++;
			if (a[7:0] == 8'h00) begin
				nx = (a[15:8] == lst) ? fst : a[15:8];
				ab = (nx == rp);
				a = {nx, 8'h00};
			end
		end
		if (ab) begin
			missed++;
			`CHK("overflow", 1'b1, ringOverflow)
		end else if (acc && !ign) begin
			nx = (a[7:0] == 8'h00) ? a[15:8] : ((a[15:8] + 8'h01 == lst) ? fst : a[15:8] + 8'h01);
			`CHK("status", {5'h0, fl}, u_mem.store[{wp, 8'h00}])
			`CHK("next page", nx, u_mem.store[{wp, 8'h01}])
			`CHK("count", len[15:0], {u_mem.store[{wp, 8'h03}], u_mem.store[{wp, 8'h02}]})
			cnt += 4;
			wp = nx;
		end
		`CHK("writes", w0 + cnt, u_mem.writes)
		rdchk("write pointer", `RBM_OFS_WPTR, {24'h0, wp});
		rdchk("missed tally", `RBM_OFS_MISSED, {24'h0, missed});
		rdchk("dma address", `RBM_OFS_DMAADDR, {16'h0, wp, 8'h00});
		$display("test %s done", n);
	endtask

	// Main sequence.
	initial begin
		seed = $urandom(46453);
		fst = 8'h10;
		lst = 8'h14;
		wp = fst;
		rp = fst;
		ctl = 3'h1;
		missed = 8'h00;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		apb(1'b1, `RBM_OFS_MISSED, 32'h5a);
		rdchk("ctrl", `RBM_OFS_CTRL, 32'h1);
		rdchk("first page", `RBM_OFS_FIRST, 32'h1);
		rdchk("end page", `RBM_OFS_END, 32'h2);
		rdchk("write ptr", `RBM_OFS_WPTR, 32'h1);
		rdchk("read ptr", `RBM_OFS_RPTR, 32'h1);
		rdchk("missed ro", `RBM_OFS_MISSED, 32'h0);
		rdchk("unmapped", 8'h20, 32'h0);
		`CHK("slverr", 1'b1, err)
		$display("test reset done");
		apb(1'b1, `RBM_OFS_FIRST, {24'h0, fst});
		apb(1'b1, `RBM_OFS_END, {24'h0, lst});
		apb(1'b1, `RBM_OFS_WPTR, {24'h0, wp});
		apb(1'b1, `RBM_OFS_RPTR, {24'h0, rp});
		ctl = 3'h0;
		apb(1'b1, `RBM_OFS_CTRL, 32'h0);
		frame("linked page", 257 + $urandom % 150, 3'h0);
		rp = 8'h11;
		apb(1'b1, `RBM_OFS_RPTR, {24'h0, rp});
		frame("overflow abort", 770 + $urandom % 100, 3'h0);
		rdchk("status ovf", `RBM_OFS_STATUS, 32'h1 << `RBM_ST_OVF);
		// Overflow service: halt, a frame while stopped is dropped, flag cleared.
		ctl = 3'h1;
		apb(1'b1, `RBM_OFS_CTRL, 32'h1);
		`CHK("stopped", 1'b1, stopped)
		// The host waits 1.6 ms, 64000 cycles, rather than polling for the stop.
		repeat (64000) @(posedge mclk);
		// Transfer counts, resend and loopback belong to blocks outside this one.
		rdchk("status halted", `RBM_OFS_STATUS, 32'h3);
		frame("halted", 80, 3'h0);
		apb(1'b1, `RBM_OFS_STATUS, 32'h1 << `RBM_ST_OVF);
		`CHK("overflow clear", 1'b0, ringOverflow)
		rp = wp;
		apb(1'b1, `RBM_OFS_RPTR, {24'h0, rp});
		ctl = 3'h0;
		apb(1'b1, `RBM_OFS_CTRL, 32'h0);
		// A frame that wraps past the ring end, with a halt arriving mid-frame.
		fork
			frame("wrap and halt", 520 + $urandom % 180, 3'h0);
			begin
				repeat (60) @(posedge mclk);
				apb(1'b1, `RBM_OFS_CTRL, 32'h1);
				`CHK("busy while halting", 1'b0, stopped)
				rdchk("status busy", `RBM_OFS_STATUS, 32'h1 << `RBM_ST_BUSY);
			end
		join
		`CHK("stopped after frame", 1'b1, stopped)
		// Each error kind, first rejected, then accepted.
		for (int e = 0; e < 3; e++) begin
			for (int ac = 0; ac < 2; ac++) begin
				ctl = ac ? 3'h6 : 3'h0;
				apb(1'b1, `RBM_OFS_CTRL, {29'h0, ctl});
				frame("error frame", 60 + $urandom % 100, 3'(1 << e));
			end
		end
		results();
	end
endmodule
